// ==== dcs_pkg.sv ====
// Shared constants for the drive command and speed source selector
package dcs_pkg;

  localparam int FREQ_W = 16;

  localparam logic [7:0] OFF_CMD_SEL    = 8'h00;
  localparam logic [7:0] OFF_SPD_SEL    = 8'h04;
  localparam logic [7:0] OFF_MAIN_SPEED = 8'h08;
  localparam logic [7:0] OFF_UPPER      = 8'h0C;
  localparam logic [7:0] OFF_LOWER      = 8'h10;
  localparam logic [7:0] OFF_GAIN       = 8'h14;
  localparam logic [7:0] OFF_PANEL      = 8'h18;
  localparam logic [7:0] OFF_STATUS     = 8'h1C;
  localparam logic [7:0] OFF_SET_FREQ   = 8'h20;
  localparam logic [7:0] OFF_COUNTER    = 8'h24;

  localparam int CMD_A_LSB     = 0;
  localparam int CMD_B_LSB     = 4;
  localparam int SPD_A_LSB     = 0;
  localparam int SPD_B_LSB     = 8;
  localparam int STAT_RUN_BIT  = 0;
  localparam int STAT_REV_BIT  = 1;
  localparam int STAT_WARN_BIT = 2;

  localparam logic [7:0]        RST_CMD_SEL = 8'h00;
  localparam logic [15:0]       RST_SPD_SEL = 16'h0000;
  localparam logic [FREQ_W-1:0] RST_MAIN    = 16'h0000;
  localparam logic [FREQ_W-1:0] RST_UPPER   = 16'h1770;
  localparam logic [FREQ_W-1:0] RST_LOWER   = 16'h0000;
  localparam logic [7:0]        RST_GAIN    = 8'h00;
  localparam logic [FREQ_W-1:0] RST_PANEL   = 16'h0000;

  // Cycles after reset before the synchronised pins are trusted
  localparam logic [1:0] SETTLE_CYCLES = 2'd3;

  localparam logic [3:0] CMD_PANEL   = 4'd0;
  localparam logic [3:0] CMD_RUN_DIR = 4'd1;
  localparam logic [3:0] CMD_FWD_REV = 4'd2;
  localparam logic [3:0] CMD_RUN_CHK = 4'd3;
  localparam logic [3:0] CMD_FR_CHK  = 4'd4;
  localparam logic [3:0] CMD_SERIAL  = 4'd5;

  localparam logic [4:0] SPD_MAIN     = 5'd0;
  localparam logic [4:0] SPD_AI1      = 5'd1;
  localparam logic [4:0] SPD_AI2      = 5'd2;
  localparam logic [4:0] SPD_PANEL    = 5'd3;
  localparam logic [4:0] SPD_BI1      = 5'd4;
  localparam logic [4:0] SPD_BI2      = 5'd5;
  localparam logic [4:0] SPD_CNT      = 5'd6;
  localparam logic [4:0] SPD_CNT_LOAD = 5'd7;
  localparam logic [4:0] SPD_PANEL_WB = 5'd8;
  localparam logic [4:0] SPD_BI1_MIN  = 5'd9;
  localparam logic [4:0] SPD_BI2_MIN  = 5'd10;
  localparam logic [4:0] SPD_CNT_ALT  = 5'd11;
  localparam logic [4:0] SPD_AI1_MUL  = 5'd12;
  localparam logic [4:0] SPD_AI2_ADD  = 5'd13;
  localparam logic [4:0] SPD_AI1_MIN  = 5'd17;
  localparam logic [4:0] SPD_AI2_MIN  = 5'd18;
  localparam logic [4:0] SPD_CNT_WB   = 5'd19;
  localparam logic [4:0] SPD_AI2_INV  = 5'd20;
  localparam logic [4:0] SPD_PNL_MUL  = 5'd21;
  localparam logic [4:0] SPD_PNL_ADD  = 5'd22;

  typedef enum logic [1:0] {ST_SETTLE, ST_CHECK, ST_RUN} dcs_state_t;

endpackage : dcs_pkg

// ==== dcs_sync.sv ====
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/10ps
module dcs_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,    // System clock
  input  wire logic         presetn, // Async reset, active low
  input  wire logic [W-1:0] d_in,    // Raw pin levels
  output logic      [W-1:0] q_out    // Synchronised levels
);
  logic [W-1:0] meta_r;

  // Only the second stage reads the first
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_r[i] <= 1'b0;
        q_out[i]  <= 1'b0;
      end else begin
        meta_r[i] <= d_in[i];
        q_out[i]  <= meta_r[i];
      end
    end
  end
endmodule : dcs_sync

// ==== dcs_select.sv ====
// Run command and set-frequency source selector with APB registers
//
// How it works
// - Terminal pins read OFF when open (high), ON when pulled to common (low).
// - Digital-input functions 89 or 90 pick the second command selection.
// - Command 0 ignores terminals; panel keys start, forward key runs forward.
// - Command 1: run OFF stops, run ON forward, run and reverse ON reverse.
// - Command 2: run ON forward, only reverse ON reverse, both OFF stop.
// - Command 3 decodes as 1, warns after reset if run not OFF.
// - Command 4 decodes as 2, warns after reset unless both OFF.
// - Command 5 takes run/stop from serial port when its protocol fits.
// - Digital-input functions 88 or 90 pick the second speed selection.
// - Speed 0..3: main setting, analog one, analog two, panel.
// - Speed 4 and 5: frequency and direction from analog one or two.
// - Speed 6 and 11: frequency from up/down counter.
// - Speed 7 as 6, counter loaded from main setting after reset.
// - Speed 8 as panel, preloaded from and written back to main setting.
// - Speed 9 and 10 as 4 and 5 without stop below lower limit.
// - Speed 12: analog one times (1 + gain times analog two), min lower.
// - Speed 13: analog two plus upper times gain times analog one, min lower.
// - Speed 17 and 18 as 1 and 2, held at least at lower limit.
// - Speed 19 as 11, counter reloaded from and written to main setting.
// - Speed 20: analog two full scale gives lower, zero gives upper.
// - Speed 21: panel times (1 + gain times analog two).
// - Speed 22: panel plus upper times gain times analog one, min lower.
`timescale 1ns/10ps
module dcs_select
  import dcs_pkg::*;
#(
  parameter int AW = 10
) (
  input  wire logic              pclk,                     // System clock
  input  wire logic              presetn,                  // Async reset, active low
  input  wire logic              psel,                     // APB select
  input  wire logic              penable,                  // APB enable
  input  wire logic              pwrite,                   // APB write
  input  wire logic [7:0]        paddr,                    // APB byte address
  input  wire logic [31:0]       pwdata,                   // APB write data
  output logic      [31:0]       prdata,                   // APB read data
  output logic                   pready,                   // APB ready
  output logic                   pslverr,                  // APB error, unmapped
  input  wire logic              run_terminal_n,           // Run pin, low is ON
  input  wire logic              reverse_terminal_n,       // Reverse pin, low is ON
  input  wire logic              forward_key,              // Panel forward key
  input  wire logic              reverse_key,              // Panel reverse key
  input  wire logic              stop_key,                 // Panel stop key
  input  wire logic              digital_input_function_88, // Alternate speed select
  input  wire logic              digital_input_function_89, // Alternate command select
  input  wire logic              digital_input_function_90, // Alternate both selects
  input  wire logic              counter_up,               // Up/down counter up pin
  input  wire logic              counter_down,             // Up/down counter down pin
  input  wire logic [AW-1:0]     analog_input_one,         // Converter sample one
  input  wire logic [AW-1:0]     analog_input_two,         // Converter sample two
  input  wire logic              serial_run,               // Serial port run request
  input  wire logic              serial_reverse,           // Serial port reverse request
  input  wire logic              serial_proto_ok,          // Serial protocol matches
  output logic                   motor_run,                // Drive running
  output logic                   motor_reverse,            // Reverse phase sequence
  output logic      [FREQ_W-1:0] set_freq,                 // Set frequency
  output logic                   on_warning                // Power-on warning shown
);

  if (AW < 4 || AW > 16) begin : g_bad_aw
    $error("dcs_select: AW must lie in 4..16");
  end

  localparam int TW = FREQ_W + AW + 11;
  localparam int SH = 8 + AW - 1;

  function automatic logic signed [TW-1:0] ext(input logic [FREQ_W-1:0] u);
    ext = $signed({{(TW-FREQ_W){1'b0}}, u});
  endfunction : ext

  function automatic logic [FREQ_W-1:0] clampf(input logic signed [TW-1:0] v,
                                               input logic [FREQ_W-1:0] lo,
                                               input logic [FREQ_W-1:0] hi);
    if (v < ext(lo)) clampf = lo;
    else if (v > ext(hi)) clampf = hi;
    else clampf = v[FREQ_W-1:0];
  endfunction : clampf

  // Registers
  logic [7:0]        cmd_sel_r;
  logic [15:0]       spd_sel_r;
  logic [FREQ_W-1:0] main_r;
  logic [FREQ_W-1:0] upper_r;
  logic [FREQ_W-1:0] lower_r;
  logic [7:0]        gain_r;
  logic [FREQ_W-1:0] panel_r;
  logic [FREQ_W-1:0] cnt_r;
  logic              panel_run_r;
  logic              panel_rev_r;
  logic [9:0]        pin_d_r;
  logic [1:0]        settle_r;
  dcs_state_t        state_r;
  logic              cmd_fresh_r;
  logic              spd_fresh_r;
  logic              cmd_chk_r;
  logic              spd_chk_r;

  // Pin synchronisation
  logic [9:0] pin_q;
  dcs_sync #(.W(10)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    ({counter_down, counter_up, digital_input_function_90,
               digital_input_function_89, digital_input_function_88,
               stop_key, reverse_key, forward_key,
               reverse_terminal_n, run_terminal_n}),
    .q_out   (pin_q)
  );

  wire run_on  = ~pin_q[0];
  wire rev_on  = ~pin_q[1];
  wire fwd_ev  = pin_q[2] & ~pin_d_r[2];
  wire rkey_ev = pin_q[3] & ~pin_d_r[3];
  wire stop_ev = pin_q[4] & ~pin_d_r[4];
  wire use_b_spd = pin_q[5] | pin_q[7];
  wire use_b_cmd = pin_q[6] | pin_q[7];
  wire up_ev   = pin_q[8] & ~pin_d_r[8];
  wire dn_ev   = pin_q[9] & ~pin_d_r[9];

  wire [3:0] cmd_sel = use_b_cmd ? cmd_sel_r[CMD_B_LSB +: 4] : cmd_sel_r[CMD_A_LSB +: 4];
  wire [4:0] spd_sel = use_b_spd ? spd_sel_r[SPD_B_LSB +: 5] : spd_sel_r[SPD_A_LSB +: 5];

  // APB decode; one wait state on every access
  wire acc      = psel & penable;
  wire acc_done = acc & pready;
  wire wr       = acc_done & pwrite;
  wire hit_cmd  = (paddr == OFF_CMD_SEL);
  wire hit_spd  = (paddr == OFF_SPD_SEL);
  wire hit_main = (paddr == OFF_MAIN_SPEED);
  wire hit_up   = (paddr == OFF_UPPER);
  wire hit_lo   = (paddr == OFF_LOWER);
  wire hit_gain = (paddr == OFF_GAIN);
  wire hit_pnl  = (paddr == OFF_PANEL);
  wire hit_stat = (paddr == OFF_STATUS);
  wire hit_freq = (paddr == OFF_SET_FREQ);
  wire hit_cnt  = (paddr == OFF_COUNTER);
  wire mapped   = hit_cmd | hit_spd | hit_main | hit_up | hit_lo | hit_gain
                | hit_pnl | hit_stat | hit_freq | hit_cnt;
  wire wr_main  = wr & hit_main;
  wire wr_pnl   = wr & hit_pnl;

  logic [31:0] rd_data;
  assign rd_data = hit_cmd  ? {24'h00_0000, cmd_sel_r} :
                   hit_spd  ? {16'h0000, spd_sel_r} :
                   hit_main ? {16'h0000, main_r} :
                   hit_up   ? {16'h0000, upper_r} :
                   hit_lo   ? {16'h0000, lower_r} :
                   hit_gain ? {24'h00_0000, gain_r} :
                   hit_pnl  ? {16'h0000, panel_r} :
                   hit_stat ? {29'h0000_0000, on_warning, motor_reverse, motor_run} :
                   hit_freq ? {16'h0000, set_freq} :
                   hit_cnt  ? {16'h0000, cnt_r} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      prdata  <= (acc & ~pready & ~pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // Analog scaling: full scale maps to the upper limit
  logic [FREQ_W+AW-1:0] ai1_prod;
  logic [FREQ_W+AW-1:0] ai2_prod;
  logic [FREQ_W+AW-1:0] bi1_prod;
  logic [FREQ_W+AW-1:0] bi2_prod;
  logic [FREQ_W+AW-1:0] inv_prod;
  logic signed [AW:0]   s1;
  logic signed [AW:0]   s2;
  logic [AW-1:0]        mag1;
  logic [AW-1:0]        mag2;
  logic [FREQ_W-1:0]    span;
  assign s1   = $signed({1'b0, analog_input_one}) - $signed({2'b01, {(AW-1){1'b0}}});
  assign s2   = $signed({1'b0, analog_input_two}) - $signed({2'b01, {(AW-1){1'b0}}});
  assign mag1 = s1[AW] ? AW'(-s1) : s1[AW-1:0];
  assign mag2 = s2[AW] ? AW'(-s2) : s2[AW-1:0];
  assign ai1_prod = upper_r * analog_input_one;
  assign ai2_prod = upper_r * analog_input_two;
  assign bi1_prod = upper_r * mag1;
  assign bi2_prod = upper_r * mag2;
  assign span     = upper_r - lower_r;
  assign inv_prod = span * analog_input_two;

  wire [FREQ_W-1:0] ai1_f = ai1_prod[FREQ_W+AW-1:AW];
  wire [FREQ_W-1:0] ai2_f = ai2_prod[FREQ_W+AW-1:AW];
  wire [FREQ_W-1:0] bi1_f = bi1_prod[FREQ_W+AW-2:AW-1];
  wire [FREQ_W-1:0] bi2_f = bi2_prod[FREQ_W+AW-2:AW-1];
  wire [FREQ_W-1:0] inv_f = upper_r - inv_prod[FREQ_W+AW-1:AW];

  // Trim terms: gain is a fraction of 256, analog offset from mid-scale
  logic signed [TW-1:0] s1x;
  logic signed [TW-1:0] s2x;
  logic signed [TW-1:0] g_x;
  logic signed [TW-1:0] t_ai1;
  logic signed [TW-1:0] t_up;
  logic signed [TW-1:0] t_pnl;
  assign s1x   = {{(TW-AW-1){s1[AW]}}, s1};
  assign s2x   = {{(TW-AW-1){s2[AW]}}, s2};
  assign g_x   = ext({8'h00, gain_r});
  assign t_ai1 = (ext(ai1_f) * g_x * s2x) >>> SH;
  assign t_up  = (ext(upper_r) * g_x * s1x) >>> SH;
  assign t_pnl = (ext(panel_r) * g_x * s2x) >>> SH;

  wire [FREQ_W-1:0] mul1_f = clampf(ext(ai1_f) + t_ai1, lower_r, upper_r);
  wire [FREQ_W-1:0] add2_f = clampf(ext(ai2_f) + t_up, lower_r, upper_r);
  wire [FREQ_W-1:0] pmul_f = clampf(ext(panel_r) + t_pnl, 16'h0000, upper_r);
  wire [FREQ_W-1:0] padd_f = clampf(ext(panel_r) + t_up, lower_r, upper_r);

  // Speed source selection
  logic [FREQ_W-1:0] f_c;
  logic              stop_c;
  logic              an_dir_c;
  logic              an_rev_c;
  always_comb begin
    f_c      = 16'h0000;
    stop_c   = 1'b0;
    an_dir_c = 1'b0;
    an_rev_c = 1'b0;
    case (spd_sel)
      SPD_MAIN: f_c = main_r;
      SPD_AI1: begin
        f_c    = ai1_f;
        stop_c = ai1_f < lower_r;
      end
      SPD_AI2: begin
        f_c    = ai2_f;
        stop_c = ai2_f < lower_r;
      end
      SPD_PANEL, SPD_PANEL_WB: f_c = (panel_r < lower_r) ? lower_r : panel_r;
      SPD_BI1, SPD_BI1_MIN: begin
        an_dir_c = 1'b1;
        an_rev_c = s1[AW];
        stop_c   = (spd_sel == SPD_BI1) && (bi1_f < lower_r);
        f_c      = (bi1_f < lower_r) ? lower_r : bi1_f;
      end
      SPD_BI2, SPD_BI2_MIN: begin
        an_dir_c = 1'b1;
        an_rev_c = s2[AW];
        stop_c   = (spd_sel == SPD_BI2) && (bi2_f < lower_r);
        f_c      = (bi2_f < lower_r) ? lower_r : bi2_f;
      end
      SPD_CNT, SPD_CNT_LOAD, SPD_CNT_ALT, SPD_CNT_WB:
        f_c = (cnt_r < lower_r) ? lower_r : cnt_r;
      SPD_AI1_MUL: f_c = mul1_f;
      SPD_AI2_ADD: f_c = add2_f;
      SPD_AI1_MIN: f_c = (ai1_f < lower_r) ? lower_r : ai1_f;
      SPD_AI2_MIN: f_c = (ai2_f < lower_r) ? lower_r : ai2_f;
      SPD_AI2_INV: f_c = inv_f;
      SPD_PNL_MUL: f_c = pmul_f;
      SPD_PNL_ADD: f_c = padd_f;
      default: stop_c = 1'b1;
    endcase
  end

  // Command source decode
  logic cmd_run_c;
  logic cmd_rev_c;
  always_comb begin
    cmd_run_c = 1'b0;
    cmd_rev_c = 1'b0;
    case (cmd_sel)
      CMD_PANEL: begin
        cmd_run_c = panel_run_r;
        cmd_rev_c = panel_rev_r;
      end
      CMD_RUN_DIR, CMD_RUN_CHK: begin
        cmd_run_c = run_on;
        cmd_rev_c = run_on & rev_on;
      end
      CMD_FWD_REV, CMD_FR_CHK: begin
        cmd_run_c = run_on | rev_on;
        cmd_rev_c = ~run_on & rev_on;
      end
      CMD_SERIAL: begin
        cmd_run_c = serial_proto_ok & serial_run;
        cmd_rev_c = serial_proto_ok & serial_reverse;
      end
      default: cmd_run_c = 1'b0;
    endcase
  end

  wire live     = (state_r == ST_RUN) & ~on_warning & ~cmd_chk_r & ~spd_chk_r;
  wire run_nxt  = live & cmd_run_c & ~stop_c;
  wire rev_nxt  = run_nxt & (an_dir_c ? an_rev_c : cmd_rev_c);
  wire warn_set = ((cmd_sel == CMD_RUN_CHK) & run_on)
                | ((cmd_sel == CMD_FR_CHK) & (run_on | rev_on));
  wire preload  = (state_r == ST_CHECK) | spd_chk_r;
  wire cmd_check = (state_r == ST_CHECK) | cmd_chk_r;

  // Startup: let the synchronisers fill before checking the terminals
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r  <= ST_SETTLE;
      settle_r <= 2'd0;
    end else begin
      case (state_r)
        ST_SETTLE: begin
          settle_r <= settle_r + 2'd1;
          if (settle_r == SETTLE_CYCLES - 2'd1) state_r <= ST_CHECK;
        end
        ST_CHECK: state_r <= ST_RUN;
        default:  state_r <= ST_RUN;
      endcase
    end
  end

  // Reset clears the selections, so the power-on check follows their first write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_fresh_r <= 1'b1;
      spd_fresh_r <= 1'b1;
      cmd_chk_r   <= 1'b0;
      spd_chk_r   <= 1'b0;
    end else begin
      cmd_chk_r <= wr & hit_cmd & cmd_fresh_r;
      spd_chk_r <= wr & hit_spd & spd_fresh_r;
      if (wr && hit_cmd) cmd_fresh_r <= 1'b0;
      if (wr && hit_spd) spd_fresh_r <= 1'b0;
    end
  end

  // Warning holds the drive stopped until the terminals are released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) on_warning <= 1'b0;
    else if (cmd_check && warn_set) on_warning <= 1'b1;
    else if (!run_on && !rev_on) on_warning <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_run     <= 1'b0;
      motor_reverse <= 1'b0;
      set_freq      <= 16'h0000;
      pin_d_r       <= 10'h000;
    end else begin
      motor_run     <= run_nxt;
      motor_reverse <= rev_nxt;
      set_freq      <= run_nxt ? f_c : 16'h0000;
      pin_d_r       <= pin_q;
    end
  end

  // Panel keys; a stop press wins over a start press
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_run_r <= 1'b0;
      panel_rev_r <= 1'b0;
    end else if (stop_ev) begin
      panel_run_r <= 1'b0;
    end else if (fwd_ev) begin
      panel_run_r <= 1'b1;
      panel_rev_r <= 1'b0;
    end else if (rkey_ev) begin
      panel_run_r <= 1'b1;
      panel_rev_r <= 1'b1;
    end
  end

  // Up/down counter, saturating between zero and the upper limit
  wire cnt_load = preload & ((spd_sel == SPD_CNT_LOAD) | (spd_sel == SPD_CNT_WB));
  wire cnt_inc  = up_ev & ~dn_ev & (cnt_r < upper_r);
  wire cnt_dec  = dn_ev & ~up_ev & (cnt_r != 16'h0000);
  logic [FREQ_W-1:0] cnt_nxt;
  assign cnt_nxt = cnt_load ? main_r :
                   cnt_inc  ? cnt_r + 16'h0001 :
                   cnt_dec  ? cnt_r - 16'h0001 : cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 16'h0000;
    else cnt_r <= cnt_nxt;
  end

  // Main setting: software write first, then automatic write-backs
  wire cnt_wb = (spd_sel == SPD_CNT_WB) & (cnt_inc | cnt_dec);
  wire pnl_wb = (spd_sel == SPD_PANEL_WB) & wr_pnl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) main_r <= RST_MAIN;
    else if (wr_main) main_r <= pwdata[FREQ_W-1:0];
    else if (cnt_wb) main_r <= cnt_nxt;
    else if (pnl_wb) main_r <= pwdata[FREQ_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) panel_r <= RST_PANEL;
    else if (wr_pnl) panel_r <= pwdata[FREQ_W-1:0];
    else if (preload && spd_sel == SPD_PANEL_WB) panel_r <= main_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_sel_r <= RST_CMD_SEL;
      spd_sel_r <= RST_SPD_SEL;
      upper_r   <= RST_UPPER;
      lower_r   <= RST_LOWER;
      gain_r    <= RST_GAIN;
    end else if (wr) begin
      if (hit_cmd)  cmd_sel_r <= pwdata[7:0];
      if (hit_spd)  spd_sel_r <= pwdata[15:0];
      if (hit_up)   upper_r   <= pwdata[FREQ_W-1:0];
      if (hit_lo)   lower_r   <= pwdata[FREQ_W-1:0];
      if (hit_gain) gain_r    <= pwdata[7:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rev_both_on;
    (live && cmd_sel == CMD_RUN_DIR && run_on && rev_on && spd_sel == SPD_MAIN)
      |=> motor_reverse == motor_run;
  endproperty
  a_rev_both_on: assert property (p_rev_both_on)
    else $error("reverse terminal not honoured");

  property p_run_off_stops;
    (cmd_sel == CMD_RUN_DIR && !run_on) |=> !motor_run;
  endproperty
  a_run_off_stops: assert property (p_run_off_stops)
    else $error("run terminal off did not stop");

  property p_cmd_alt;
    (live && use_b_cmd && cmd_sel_r[CMD_B_LSB +: 4] == CMD_FWD_REV && rev_on && !run_on
     && spd_sel == SPD_MAIN && main_r != 16'h0000) |=> motor_run && motor_reverse;
  endproperty
  a_cmd_alt: assert property (p_cmd_alt)
    else $error("second command selection not used");

  property p_fwd_wins;
    (cmd_sel == CMD_FWD_REV && run_on) |=> !motor_reverse;
  endproperty
  a_fwd_wins: assert property (p_fwd_wins)
    else $error("run terminal should force forward");

  property p_on_warn;
    (cmd_check && cmd_sel == CMD_RUN_CHK && run_on) |=> on_warning ##1 !motor_run;
  endproperty
  a_on_warn: assert property (p_on_warn)
    else $error("power-on warning missing");

  property p_serial_gate;
    (!serial_proto_ok && cmd_sel == CMD_SERIAL) |=> !motor_run;
  endproperty
  a_serial_gate: assert property (p_serial_gate)
    else $error("serial run without protocol");

  property p_main_freq;
    (run_nxt && spd_sel == SPD_MAIN) |=> set_freq == $past(main_r);
  endproperty
  a_main_freq: assert property (p_main_freq)
    else $error("set frequency not from main setting");

  property p_min_hold;
    (run_nxt && spd_sel == SPD_AI1_MIN) |=> set_freq >= $past(lower_r);
  endproperty
  a_min_hold: assert property (p_min_hold)
    else $error("set frequency below lower limit");

  property p_reserved;
    (spd_sel == 5'd14 || spd_sel == 5'd23) |=> !motor_run && set_freq == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved speed source ran");

endmodule : dcs_select

// ==== dcs_partner.sv ====
// Far-side switch model for the run and reverse terminals
`timescale 1ns/10ps
module dcs_partner (
  input  wire logic run_on,            // Run switch closed
  input  wire logic rev_on,            // Reverse switch closed
  output logic      run_terminal_n,    // Run pin level
  output logic      reverse_terminal_n // Reverse pin level
);
  // Open contact floats high, closed ties to common
  assign run_terminal_n     = ~run_on;
  assign reverse_terminal_n = ~rev_on;
endmodule : dcs_partner

// ==== dcs_select_test.sv ====
// Self-checking bench for the command and speed source selector
`timescale 1ns/10ps
module dcs_select_test;
  import dcs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, motor_run, motor_reverse, on_warning, run_terminal_n, reverse_terminal_n;
  logic forward_key = 0, reverse_key = 0, stop_key = 0, serial_run = 0, serial_reverse = 0;
  logic digital_input_function_88 = 0, digital_input_function_89 = 0, cu = 0;
  logic [9:0] ai1 = '0, ai2 = '0;
  logic digital_input_function_90 = 0, serial_proto_ok = 0, run_on = 0, rev_on = 0, er, ev, es;
  logic [FREQ_W-1:0] set_freq;
  int err_count = 0, check_count = 0;
  always #20 pclk = ~pclk;
  dcs_partner u_far (.run_on, .rev_on, .run_terminal_n, .reverse_terminal_n);
  // Down steps left idle; up steps cover the counter path
  dcs_select dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .run_terminal_n, .reverse_terminal_n, .forward_key, .reverse_key, .stop_key,
    .digital_input_function_88, .digital_input_function_89, .digital_input_function_90,
    .counter_up(cu), .counter_down(1'b0), .analog_input_one(ai1),
    .analog_input_two(ai2), .serial_run, .serial_reverse, .serial_proto_ok, .motor_run,
    .motor_reverse, .set_freq, .on_warning);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    es = pslverr;
    {psel, penable} <= 2'b00;
  endtask : bus
  // Pins need two edges through the synchroniser, so wait six
  task automatic stat(input logic run, input logic reverse_terminal, input logic [15:0] f);
    repeat (6) @(posedge pclk);
    bus(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(rd, {29'h0, 1'b0, reverse_terminal, run});
    bus(1'b0, OFF_SET_FREQ, 32'h0000_0000);
    chk(rd, {16'h0000, f});
  endtask : stat
  task automatic print_verdict;
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, OFF_UPPER, 32'h0000_0000);
    chk(rd, 32'h0000_1770);
    bus(1'b0, 8'h30, 32'h0000_0000);
    chk({rd[31:1], es}, 32'h0000_0001);
    bus(1'b1, OFF_MAIN_SPEED, 32'h0000_0100);
    for (int m = 1; m <= 2; m++) begin
      bus(1'b1, OFF_CMD_SEL, 32'(m));
      for (int i = 0; i < 4; i++) begin
        run_on <= i[1];
        rev_on <= i[0];
        er = (m == 1) ? i[1] : (i[1] | i[0]);
        ev = (m == 1) ? (i[1] & i[0]) : (!i[1] & i[0]);
        stat(er, ev, er ? 16'h0100 : 16'h0000);
      end
    end
    run_on <= 1'b0;
    bus(1'b1, OFF_CMD_SEL, 32'h0000_0021);
    stat(1'b0, 1'b0, 16'h0000);
    digital_input_function_89 <= 1'b1;
    stat(1'b1, 1'b1, 16'h0100);
    digital_input_function_89 <= 1'b0;
    digital_input_function_90 <= 1'b1;
    stat(1'b1, 1'b1, 16'h0100);
    digital_input_function_90 <= 1'b0;
    run_on <= 1'b1;
    rev_on <= 1'b0;
    bus(1'b1, OFF_CMD_SEL, 32'h0000_0011);
    bus(1'b1, OFF_PANEL, 32'h0000_0200);
    bus(1'b1, OFF_SPD_SEL, 32'h0000_0003);
    stat(1'b1, 1'b0, 16'h0200);
    digital_input_function_88 <= 1'b1;
    stat(1'b1, 1'b0, 16'h0100);
    bus(1'b1, OFF_SPD_SEL, 32'h0000_0E03);
    stat(1'b0, 1'b0, 16'h0000);
    digital_input_function_88 <= 1'b0;
    bus(1'b1, OFF_CMD_SEL, 32'h0000_0000);
    stat(1'b0, 1'b0, 16'h0000);
    forward_key <= 1'b1;
    stat(1'b1, 1'b0, 16'h0200);
    forward_key <= 1'b0;
    stop_key <= 1'b1;
    stat(1'b0, 1'b0, 16'h0000);
    stop_key <= 1'b0;
    reverse_key <= 1'b1;
    stat(1'b1, 1'b1, 16'h0200);
    bus(1'b1, OFF_CMD_SEL, 32'h0000_0005);
    serial_run <= 1'b1;
    serial_proto_ok <= 1'b1;
    stat(1'b1, 1'b0, 16'h0200);
    serial_reverse <= 1'b1;
    stat(1'b1, 1'b1, 16'h0200);
    serial_proto_ok <= 1'b0;
    stat(1'b0, 1'b0, 16'h0000);
    reverse_key <= 1'b0;
    for (int m = 3; m <= 4; m++) begin
      presetn <= 1'b0;
      run_on <= (m == 3);
      rev_on <= (m == 4);
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      bus(1'b1, OFF_MAIN_SPEED, 32'h0000_0100);
      bus(1'b1, OFF_CMD_SEL, 32'(m));
      bus(1'b0, OFF_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0004);
      run_on <= 1'b0;
      rev_on <= 1'b0;
      stat(1'b0, 1'b0, 16'h0000);
    end
    bus(1'b1, OFF_SPD_SEL, 32'h0000_0007);
    run_on <= 1'b1;
    stat(1'b1, 1'b0, 16'h0100);
    repeat (2) begin
      cu <= 1'b1;
      repeat (3) @(posedge pclk);
      cu <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    stat(1'b1, 1'b0, 16'h0102);
    ai1 <= 10'h200;
    bus(1'b1, OFF_SPD_SEL, 32'h0000_0001);
    stat(1'b1, 1'b0, 16'h0BB8);
    ai1 <= 10'h000;
    bus(1'b1, OFF_SPD_SEL, 32'h0000_0004);
    stat(1'b1, 1'b1, 16'h1770);
    ai1 <= 10'h200;
    bus(1'b1, OFF_GAIN, 32'h0000_0080);
    bus(1'b1, OFF_SPD_SEL, 32'h0000_000C);
    stat(1'b1, 1'b0, 16'h05DC);
    bus(1'b1, OFF_SPD_SEL, 32'h0000_0014);
    stat(1'b1, 1'b0, 16'h1770);
    print_verdict();
  end
endmodule : dcs_select_test
